// >>> hdl/pard_adc_map.svh
`ifndef PARD_ADC_MAP_SVH
`define PARD_ADC_MAP_SVH

// Register addresses on the serial slave register space
`define PARD_ADDR_RESULT_LOW 3'h3
`define PARD_ADDR_RESULT_HIGH 3'h4
`define PARD_ADDR_CHIP_ID 3'h5

// Conversion geometry
`define PARD_RESULT_W 12
`define PARD_INTEG_CYCLES 8192
`define PARD_INTEG_W 13
`define PARD_FULL_SCALE 4096

// Upper and lower result register layout
`define PARD_HI_BELOW_BIT 7
`define PARD_HI_OVR_BIT 6
`define PARD_HI_NIBBLE_MSB 3
`define PARD_LO_BYTE_MSB 7

// Identification layout
`define PARD_ID_REV_LSB 5
`define PARD_ID_PART_MSB 4

// Reset and fill values
`define PARD_BYTE_ZERO 8'h00
`define PARD_RESULT_ZERO 12'h000
`define PARD_RESULT_MAX 12'hfff

`endif

// >>> hdl/pard_pkg.sv
package pard_pkg;

    typedef enum logic [2:0] {
        PARD_IDLE,
        PARD_ZERO_INTEG,
        PARD_ZERO_RUNDOWN,
        PARD_SIG_INTEG,
        PARD_SIG_RUNDOWN
    } pard_state_t;

    // Source switched onto the integrator input
    typedef enum logic [1:0] {
        PARD_SRC_NONE,
        PARD_SRC_ZERO,
        PARD_SRC_SIGNAL,
        PARD_SRC_REFERENCE
    } pard_src_t;

    typedef struct packed {
        logic dump;
        pard_src_t src;
        logic volt_sel;
        logic [2:0] port;
    } pard_front_t;

    typedef struct packed {
        logic below;
        logic overrange;
        logic busy;
    } pard_status_t;

endpackage

// >>> hdl/pard_step_counter.sv
`timescale 1ns/100ps
`include "pard_adc_map.svh"

module pard_step_counter #(
    parameter int WIDTH = `PARD_RESULT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic inc,
    output logic [WIDTH-1:0] value,
    output logic at_max
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = '0;
        end else if (inc && !at_max) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Saturates rather than wraps so a stuck comparator cannot alias to a small count
    assign at_max = &cnt_q;
    assign value = cnt_q;

endmodule

// >>> hdl/pard_adc_readout.sv
// Summary of operation
// - While a port is powered, its averaged current or voltage is readable.
// - Each conversion yields a 12-bit result with input offset subtracted.
// - Integration lasts exactly 8192 device clock cycles.
// - Span is 4096 counts, codes zero through 12-bit maximum.
// - Address 011 reads result bits 7..0 on D7..D0.
// - Address 100 reads bits 11..8 on D3..D0, flags D7/D6, D5/D4 reserved.
// - During each rundown phase of a conversion the result registers show the live counter.
// - On completion the final count is frozen until the next conversion.
// - D7 of address 100 reads 1 while integrator node is below threshold.
// - D6 of address 100 reads 1 when count overflow was detected.
// - Address 101 is hardwired: revision in D7..D5, part code in D4..D0.
// - Port-4 control bit selects currents (0) or port voltage (1).
`timescale 1ns/100ps
`include "pard_adc_map.svh"

module pard_adc_readout #(
    parameter int RESULT_W = `PARD_RESULT_W,
    parameter int INTEG_W = `PARD_INTEG_W,
    // Arbitrary identification values
    parameter logic [2:0] SILICON_REVISION_CODE = 3'h1,
    parameter logic [4:0] PART_CODE_FIELD = 5'h01
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_req,
    input wire logic [2:0] sample_port,
    input wire logic port_powered,
    input wire logic adc_input_select,
    input wire logic integrator_cap_node,
    input wire logic reg_rd,
    input wire logic [2:0] reg_addr,
    output logic [7:0] reg_rdata,
    output pard_pkg::pard_front_t front,
    output pard_pkg::pard_status_t status
);

    ////////////////////////////////////////////////////////////////////////////////
    // Counters

    pard_pkg::pard_state_t state_q;
    pard_pkg::pard_state_t state_d;
    logic integ_clr;
    logic integ_inc;
    logic [INTEG_W-1:0] integ_value;
    logic integ_done;
    logic run_clr;
    logic run_inc;
    logic [RESULT_W-1:0] run_value;
    logic run_full;

    // Integration timer: 2^13 states, so the terminal count is the 8192nd cycle
    pard_step_counter #(
        .WIDTH(INTEG_W)
    ) u_integ_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(integ_clr),
        .inc(integ_inc),
        .value(integ_value),
        .at_max(integ_done)
    );

    // Rundown counter spans the 4096-code range
    pard_step_counter #(
        .WIDTH(RESULT_W)
    ) u_rundown (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(run_clr),
        .inc(run_inc),
        .value(run_value),
        .at_max(run_full)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic below_q;
    logic below_d;
    logic [2:0] port_q;
    logic [2:0] port_d;
    logic volt_q;
    logic volt_d;
    logic [RESULT_W-1:0] offset_q;
    logic [RESULT_W-1:0] offset_d;
    logic [RESULT_W-1:0] result_q;
    logic [RESULT_W-1:0] result_d;
    logic ovr_q;
    logic ovr_d;
    logic start;
    logic rundown_end;

    assign start = sample_req && port_powered;
    // Rundown stops when the node climbs back above threshold or the count runs out
    assign rundown_end = !below_q || run_full;

    always_comb begin
        state_d = state_q;
        port_d = port_q;
        volt_d = volt_q;
        offset_d = offset_q;
        result_d = result_q;
        ovr_d = ovr_q;
        integ_clr = 1'b1;
        integ_inc = 1'b0;
        run_clr = 1'b1;
        run_inc = 1'b0;
        unique case (state_q)
            pard_pkg::PARD_IDLE: begin
                if (start) begin
                    state_d = pard_pkg::PARD_ZERO_INTEG;
                    port_d = sample_port;
                    volt_d = adc_input_select;
                    ovr_d = 1'b0;
                    result_d = `PARD_RESULT_ZERO;
                end
            end
            pard_pkg::PARD_ZERO_INTEG: begin
                integ_clr = 1'b0;
                integ_inc = 1'b1;
                if (integ_done) begin
                    state_d = pard_pkg::PARD_ZERO_RUNDOWN;
                end
            end
            pard_pkg::PARD_ZERO_RUNDOWN: begin
                run_clr = 1'b0;
                run_inc = 1'b1;
                result_d = run_value;
                if (rundown_end) begin
                    offset_d = run_value;
                    state_d = pard_pkg::PARD_SIG_INTEG;
                end
            end
            pard_pkg::PARD_SIG_INTEG: begin
                integ_clr = 1'b0;
                integ_inc = 1'b1;
                if (integ_done) begin
                    state_d = pard_pkg::PARD_SIG_RUNDOWN;
                end
            end
            pard_pkg::PARD_SIG_RUNDOWN: begin
                run_clr = 1'b0;
                run_inc = 1'b1;
                result_d = run_value;
                if (rundown_end) begin
                    state_d = pard_pkg::PARD_IDLE;
                    if (below_q) begin
                        ovr_d = 1'b1;
                        result_d = `PARD_RESULT_MAX;
                    end else if (run_value > offset_q) begin
                        result_d = run_value - offset_q;
                    end else begin
                        result_d = `PARD_RESULT_ZERO;
                    end
                end
            end
        endcase
        // A port dropping power aborts the pass; the last value shown stays put
        if (state_q != pard_pkg::PARD_IDLE && !port_powered) begin
            state_d = pard_pkg::PARD_IDLE;
        end
    end

    always_comb begin
        below_d = integrator_cap_node;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= pard_pkg::PARD_IDLE;
            port_q <= 3'h0;
            volt_q <= 1'b0;
            offset_q <= `PARD_RESULT_ZERO;
            result_q <= `PARD_RESULT_ZERO;
            ovr_q <= 1'b0;
            below_q <= 1'b0;
        end else begin
            state_q <= state_d;
            port_q <= port_d;
            volt_q <= volt_d;
            offset_q <= offset_d;
            result_q <= result_d;
            ovr_q <= ovr_d;
            below_q <= below_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Front-end control

    pard_pkg::pard_front_t front_d;
    pard_pkg::pard_front_t front_q;

    always_comb begin
        front_d.dump = 1'b0;
        // Covers unused state codes so the struct never infers a latch
        front_d.src = pard_pkg::PARD_SRC_NONE;
        front_d.port = port_d;
        front_d.volt_sel = volt_d;
        unique case (state_d)
            pard_pkg::PARD_IDLE: begin
                front_d.dump = 1'b1;
                front_d.src = pard_pkg::PARD_SRC_NONE;
            end
            pard_pkg::PARD_ZERO_INTEG: begin
                front_d.src = pard_pkg::PARD_SRC_ZERO;
            end
            pard_pkg::PARD_SIG_INTEG: begin
                front_d.src = pard_pkg::PARD_SRC_SIGNAL;
            end
            pard_pkg::PARD_ZERO_RUNDOWN, pard_pkg::PARD_SIG_RUNDOWN: begin
                front_d.src = pard_pkg::PARD_SRC_REFERENCE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            front_q <= '{dump: 1'b1, src: pard_pkg::PARD_SRC_NONE, volt_sel: 1'b0,
                port: 3'h0};
        end else begin
            front_q <= front_d;
        end
    end

    assign front = front_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] high_byte;
    logic [7:0] id_byte;

    always_comb begin
        high_byte = `PARD_BYTE_ZERO; // Reserved test bits read zero
        high_byte[`PARD_HI_BELOW_BIT] = below_q;
        high_byte[`PARD_HI_OVR_BIT] = ovr_q;
        high_byte[`PARD_HI_NIBBLE_MSB:0] = result_q[RESULT_W-1:`PARD_LO_BYTE_MSB+1];
        id_byte = {SILICON_REVISION_CODE, PART_CODE_FIELD};
    end

    // Pure mux into a holding flop: nothing here touches sequencer state
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                `PARD_ADDR_RESULT_LOW: rdata_d = result_q[`PARD_LO_BYTE_MSB:0];
                `PARD_ADDR_RESULT_HIGH: rdata_d = high_byte;
                `PARD_ADDR_CHIP_ID: rdata_d = id_byte;
                default: rdata_d = `PARD_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= `PARD_BYTE_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Status

    logic busy_q;
    logic busy_d;

    always_comb begin
        busy_d = (state_d != pard_pkg::PARD_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    assign status = '{below: below_q, overrange: ovr_q, busy: busy_q};

endmodule

// >>> bench/pard_adc_readout_properties.sv
`timescale 1ns/100ps
module pard_adc_readout_properties #(
    parameter logic [2:0] SILICON_REVISION_CODE = 3'h1,
    parameter logic [4:0] PART_CODE_FIELD = 5'h01
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_req,
    input wire logic port_powered,
    input wire logic reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input pard_pkg::pard_front_t front,
    input pard_pkg::pard_status_t status
);
    int run_q;
    int run_d;
    logic integ;
    logic go;
    assign integ = front.src inside {pard_pkg::PARD_SRC_ZERO, pard_pkg::PARD_SRC_SIGNAL};
    assign go = !status.busy && sample_req && port_powered;
    // Length of the current integrate run, judged when the reference switches in
    always_comb run_d = integ ? run_q + 1 : 0;
    always_ff @(posedge ref_clk) run_q <= rst ? 0 : run_d;
    // Cycles spent in the current rundown, to predict the live count on the bus
    int ref_q;
    int ref_d;
    logic refr;
    assign refr = front.src == pard_pkg::PARD_SRC_REFERENCE;
    always_comb ref_d = refr ? ref_q + 1 : 0;
    always_ff @(posedge ref_clk) ref_q <= rst ? 0 : ref_d;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    property p_id;
        reg_rd && reg_addr == 3'h5 |=> reg_rdata[7:5] == SILICON_REVISION_CODE
            && reg_rdata[4:0] == PART_CODE_FIELD;
    endproperty
    a_id: assert property (p_id) else $error("id byte wrong");
    property p_unmap;
        reg_rd && !(reg_addr inside {[3'h3:3'h5]}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_flags;
        reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:4]
            == {$past(status.below), $past(status.overrange), 2'h0};
    endproperty
    a_flags: assert property (p_flags) else $error("upper flags wrong");
    property p_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_start;
        go |=> status.busy && !status.overrange && !front.dump
            && front.src == pard_pkg::PARD_SRC_ZERO;
    endproperty
    a_start: assert property (p_start) else $error("start wrong");
    property p_len;
        $past(integ) && front.src == pard_pkg::PARD_SRC_REFERENCE |-> run_q == 32'h2000;
    endproperty
    a_len: assert property (p_len) else $error("integrate length wrong");
    property p_abort;
        status.busy && !port_powered |-> ##[1:2] !status.busy;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not taken");
    property p_idle;
        !status.busy |-> front.dump && front.src == pard_pkg::PARD_SRC_NONE;
    endproperty
    a_idle: assert property (p_idle) else $error("idle front wrong");
    property p_live;
        reg_rd && reg_addr == 3'h3 && refr && ref_q > 0
            |=> reg_rdata == 8'($past(ref_q) - 1);
    endproperty
    a_live: assert property (p_live) else $error("live count not shown");
    c_ovr: cover property ($rose(status.overrange));
    c_abort: cover property (status.busy && !port_powered);
    c_busy_rd: cover property (status.busy && reg_rd);
endmodule

bind pard_adc_readout pard_adc_readout_properties #(
    .SILICON_REVISION_CODE(SILICON_REVISION_CODE),
    .PART_CODE_FIELD(PART_CODE_FIELD)
) u_props (
    .ref_clk(ref_clk),
    .rst(rst),
    .sample_req(sample_req),
    .port_powered(port_powered),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .front(front),
    .status(status)
);

// >>> bench/pard_integrator_model.sv
`timescale 1ns/100ps
module pard_integrator_model (
    input wire logic ref_clk,
    input pard_pkg::pard_front_t front,
    input wire logic [15:0][12:0] level,
    input wire logic [5:0] offset,
    output logic integrator_cap_node
);
    int charge = 0;
    // Clamped at zero so a late stop never carries charge into the next pass
    always @(posedge ref_clk) begin
        if (front.dump)
            charge <= 0;
        else if (front.src == pard_pkg::PARD_SRC_ZERO)
            charge <= charge + offset;
        else if (front.src == pard_pkg::PARD_SRC_SIGNAL)
            charge <= charge + offset + level[{front.volt_sel, front.port}];
        else if (front.src == pard_pkg::PARD_SRC_REFERENCE)
            charge <= charge > 14'h2000 ? charge - 14'h2000 : 0;
    end
    assign integrator_cap_node = charge > 0;
endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
    // Arbitrary identification values
    localparam logic [2:0] REV = 3'h5;
    localparam logic [4:0] PART = 5'h0a;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic sample_req = 1'h0;
    logic [2:0] sample_port = 3'h0;
    logic port_powered = 1'h0;
    logic adc_input_select = 1'h0;
    logic integrator_cap_node;
    logic reg_rd = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_rdata;
    pard_pkg::pard_front_t front;
    pard_pkg::pard_status_t status;
    logic [15:0][12:0] level;
    logic [5:0] offset = 6'h01;
    int fail_count = 0;
    int tests_run = 0;
    int plan_q[$];
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    pard_adc_readout #(.SILICON_REVISION_CODE(REV), .PART_CODE_FIELD(PART)) dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .sample_req(sample_req),
        .sample_port(sample_port),
        .port_powered(port_powered),
        .adc_input_select(adc_input_select),
        .integrator_cap_node(integrator_cap_node),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_rdata(reg_rdata),
        .front(front),
        .status(status)
    );
    pard_integrator_model u_far (
        .ref_clk(ref_clk),
        .front(front),
        .level(level),
        .offset(offset),
        .integrator_cap_node(integrator_cap_node)
    );
    ////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    // Port and select are scrambled after the start, so only latched values count
    task automatic convert(input logic [2:0] p, input logic vs, input int lv);
        logic [7:0] v;
        logic [11:0] r;
        r = lv > 4095 ? 12'hfff : 12'(lv);
        @(posedge ref_clk);
        level[{vs, p}] <= 13'(lv);
        level[{~vs, ~p}] <= 13'(lv + 1);
        sample_req <= 1'h1;
        sample_port <= p;
        adc_input_select <= vs;
        @(posedge ref_clk);
        sample_req <= 1'h0;
        sample_port <= ~p;
        adc_input_select <= ~vs;
        repeat (4) @(posedge ref_clk);
        rd(3'h4, v);
        check("below_flag", 8'h80, v & 8'h80);
        // Reads keep coming during the run so any side effect on the result would show
        for (int n = 0; status.busy !== 1'h0; n++) begin
            if (n > 20000) begin
                fail_count++;
                end_of_test;
            end
            rd(n[2:0], v);
        end
        rd(3'h3, v);
        check("result_low", r[7:0], v);
        rd(3'h4, v);
        check("result_high", {1'h0, lv > 4095, 2'h0, r[11:8]}, v);
        rd(3'h3, v);
        check("held_low", r[7:0], v);
    endtask
    initial begin
        logic [7:0] v;
        void'($urandom(28));
        for (int i = 0; i < 16; i++)
            level[i] = 13'($urandom_range(3000));
        offset = 6'($urandom_range(63, 1));
        plan_q = '{$urandom_range(3000), $urandom_range(3000), 5000, 0};
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        port_powered <= 1'h1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], v);
            check("reg", a == 5 ? {REV, PART} : 8'h00, v);
        end
        for (int k = 0; k < 4; k++)
            convert(3'($urandom_range(7)), k[0], plan_q[k]);
        @(posedge ref_clk);
        sample_req <= 1'h1;
        repeat (50) @(posedge ref_clk);
        port_powered <= 1'h0;
        sample_req <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1 check("busy", 8'h00, {7'h0, status.busy});
        end_of_test;
    end
endmodule
